// *** verilog/bocp_params.svh ***
// constants for the bit-or-carry and stack-pop execution block
`ifndef BOCP_PARAMS_SVH
`define BOCP_PARAMS_SVH
`define BOCP_OP_OR_BIT      8'h72
`define BOCP_OP_OR_NBIT     8'ha0
`define BOCP_OP_POP         8'hd0
`define BOCP_INSN_BYTES     2'h2
`define BOCP_INSN_CYCLES    2'h2
`define BOCP_SP_ADDR        8'h81
`define BOCP_SP_RESET       8'h07
`define BOCP_PSW_CY_BIT     7
`define BOCP_PSW_RESET      8'h00
`define BOCP_SP_STEP        8'h01
`endif

// *** verilog/bocp_pkg.sv ***
// types for the bit-or-carry and stack-pop execution block
package bocp_pkg;
  typedef enum logic [1:0] {
    BOCP_IDLE,
    BOCP_EXEC,
    BOCP_DONE
  } bocp_state_e;
  typedef enum logic [1:0] {
    BOCP_K_NONE,
    BOCP_K_OR,
    BOCP_K_ORN,
    BOCP_K_POP
  } bocp_kind_e;
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] operand;
  } bocp_insn_s;
  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] data;
  } bocp_wr_s;
endpackage : bocp_pkg

// *** verilog/bocp_decode.sv ***
// opcode decoder for the three supported instructions
`timescale 1ns/1ns
`include "bocp_params.svh"
module bocp_decode
  import bocp_pkg::*;
(
  input  wire logic [7:0] opcode,
  output bocp_kind_e      kind,
  output logic            legal
);
  always_comb begin
    kind  = BOCP_K_NONE;
    legal = 1'b1;
    unique case (opcode)
      `BOCP_OP_OR_BIT:  kind = BOCP_K_OR;
      `BOCP_OP_OR_NBIT: kind = BOCP_K_ORN;
      `BOCP_OP_POP:     kind = BOCP_K_POP;
      default:          legal = 1'b0;
    endcase
  end
endmodule : bocp_decode

// *** verilog/bocp_core.sv ***
// execution block: carry-or with bit, carry-or with inverse bit, stack pop
// Function
// - carry set when source is one
// - inverse form leaves addressed bit untouched
// - only the carry flag may change
// - opcode 72h: or true bit, 2 cycles
// - opcode a0h: or inverse bit, 2 cycles
// - pop reads ram at stack pointer
// - pop then decrements stack pointer once
// - popped byte written to destination, no flags
// - pop to stack pointer: decrement then write
// - opcode d0h: pop direct, 2 cycles
`timescale 1ns/1ns
`include "bocp_params.svh"
module bocp_core
  import bocp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       insn_valid,
  input  bocp_insn_s      insn,
  input  wire logic       bit_value,
  input  wire logic [7:0] ram_rdata,
  output logic            insn_ready,
  output logic            insn_done,
  output logic            insn_illegal,
  output logic [1:0]      insn_length,
  output logic [7:0]      bit_addr,
  output logic [7:0]      ram_raddr,
  output logic            ram_re,
  output bocp_wr_s        dir_wr,
  output logic [7:0]      stack_pointer,
  output logic [7:0]      psw_flags
);
  typedef struct packed {
    bocp_state_e state;
    bocp_kind_e  kind;
    logic [7:0]  operand;
    logic [7:0]  sp;
    logic [7:0]  psw;
    logic        done;
    logic        illegal;
    logic [1:0]  len;
    logic [7:0]  baddr;
    logic [7:0]  raddr;
    logic        re;
    bocp_wr_s    wr;
  } bocp_core_s;

  bocp_core_s state_reg;
  bocp_core_s state_next;
  bocp_kind_e dec_kind;
  logic       dec_legal;
  logic       src_bit;
  logic [7:0] sp_dec;

  bocp_decode u_dec (
    .opcode (insn.opcode),
    .kind   (dec_kind),
    .legal  (dec_legal)
  );

  assign sp_dec  = state_reg.sp - `BOCP_SP_STEP;
  assign src_bit = (state_reg.kind == BOCP_K_ORN) ? ~bit_value : bit_value;

  always_comb begin
    state_next         = state_reg;
    state_next.done    = 1'b0;
    state_next.illegal = 1'b0;
    state_next.re      = 1'b0;
    state_next.wr.we   = 1'b0;
    unique case (state_reg.state)
      BOCP_IDLE: begin
        if (insn_valid) begin
          if (dec_legal) begin
            state_next.state   = BOCP_EXEC;
            state_next.kind    = dec_kind;
            state_next.operand = insn.operand;
            state_next.len     = `BOCP_INSN_BYTES;
            state_next.baddr   = insn.operand;
            if (dec_kind == BOCP_K_POP) begin
              state_next.raddr = state_reg.sp;
              state_next.re    = 1'b1;
            end
          end else begin
            state_next.illegal = 1'b1;
          end
        end
      end
      BOCP_EXEC: begin
        state_next.state = BOCP_DONE;
        state_next.done  = 1'b1;
        if (state_reg.kind == BOCP_K_POP) begin
          state_next.sp      = sp_dec;
          state_next.wr.we   = 1'b1;
          state_next.wr.addr = state_reg.operand;
          state_next.wr.data = ram_rdata;
          if (state_reg.operand == `BOCP_SP_ADDR) begin
            state_next.sp = ram_rdata;
          end
        end else if (src_bit) begin
          state_next.psw[`BOCP_PSW_CY_BIT] = 1'b1;
        end
      end
      BOCP_DONE: begin
        state_next.state = BOCP_IDLE;
      end
      default: state_next.state = BOCP_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg         <= '0;
      state_reg.state   <= BOCP_IDLE;
      state_reg.sp      <= `BOCP_SP_RESET;
      state_reg.psw     <= `BOCP_PSW_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign insn_ready    = (state_reg.state == BOCP_IDLE);
  assign insn_done     = state_reg.done;
  assign insn_illegal  = state_reg.illegal;
  assign insn_length   = state_reg.len;
  assign bit_addr      = state_reg.baddr;
  assign ram_raddr     = state_reg.raddr;
  assign ram_re        = state_reg.re;
  assign dir_wr        = state_reg.wr;
  assign stack_pointer = state_reg.sp;
  assign psw_flags     = state_reg.psw;

  // assertions
  logic [7:0] sp_prev;
  logic [7:0] psw_prev;
  // cycle number of the instruction in flight, 0 when idle
  logic [1:0] busy_age;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sp_prev  <= `BOCP_SP_RESET;
      psw_prev <= `BOCP_PSW_RESET;
      busy_age <= 2'h0;
    end else begin
      sp_prev  <= state_reg.sp;
      psw_prev <= state_reg.psw;
      if (insn_ready && insn_valid && dec_legal) begin
        busy_age <= 2'h1;
      end else if (busy_age == 2'h1) begin
        busy_age <= 2'h2;
      end else begin
        busy_age <= 2'h0;
      end
    end
  end

  AST_OR_SETS_CARRY: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind != BOCP_K_POP && src_bit)
      |=> psw_flags[`BOCP_PSW_CY_BIT]) else $error("carry not set by or");
  AST_OR_KEEPS_CARRY: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind != BOCP_K_POP && !src_bit)
      |=> $stable(psw_flags)) else $error("carry changed on zero source");
  AST_INV_SOURCE: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind == BOCP_K_ORN && !bit_value)
      |=> psw_flags[`BOCP_PSW_CY_BIT] && !dir_wr.we) else $error("inverse form wrong");
  AST_ONLY_CARRY: assert property (@(posedge clock) disable iff (rst)
    (psw_flags & 8'h7f) == (psw_prev & 8'h7f)) else $error("non-carry flag changed");
  AST_TWO_CYCLES: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && dec_legal) |-> ##2 insn_done && insn_length == 2'h2)
    else $error("instruction not done in two cycles");
  AST_POP_READ: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && insn.opcode == `BOCP_OP_POP)
      |=> ram_re && ram_raddr == stack_pointer) else $error("pop read address wrong");
  AST_POP_DEC: assert property (@(posedge clock) disable iff (rst)
    (dir_wr.we && dir_wr.addr != `BOCP_SP_ADDR) |-> stack_pointer == sp_prev - 8'h01)
    else $error("stack pointer not decremented");
  AST_POP_WRITE: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind == BOCP_K_POP)
      |=> dir_wr.we && dir_wr.data == $past(ram_rdata) && $stable(psw_flags))
    else $error("pop write wrong");
  AST_POP_SP_DEST: assert property (@(posedge clock) disable iff (rst)
    (dir_wr.we && dir_wr.addr == `BOCP_SP_ADDR) |-> stack_pointer == dir_wr.data)
    else $error("pop to stack pointer wrong");
  AST_ILLEGAL: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && !dec_legal) |=> insn_illegal && insn_ready)
    else $error("unknown opcode accepted");

  AST_ORN_TWO_CYCLES: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && insn.opcode == `BOCP_OP_OR_NBIT)
      |-> ##2 (insn_done && !dir_wr.we))
    else $error("inverse or not done in two cycles");

  AST_POP_TWO_CYCLES: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && insn.opcode == `BOCP_OP_POP)
      |-> ##2 (insn_done && dir_wr.we))
    else $error("pop not done in two cycles");

  AST_POP_DEST: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && insn.opcode == `BOCP_OP_POP)
      |-> ##2 (dir_wr.addr == $past(insn.operand, 2)))
    else $error("pop destination address wrong");

  AST_OR_BIT_ADDR: assert property (@(posedge clock) disable iff (rst)
    (insn_ready && insn_valid && insn.opcode == `BOCP_OP_OR_BIT)
      |=> (bit_addr == $past(insn.operand) && !ram_re))
    else $error("or bit address wrong");

  AST_BIT_ADDR_HOLD: assert property (@(posedge clock) disable iff (rst)
    !(insn_ready && insn_valid && dec_legal)
      |=> $stable(bit_addr))
    else $error("bit address moved without accept");

  AST_OR_TRUE_SOURCE: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind == BOCP_K_OR && bit_value)
      |=> psw_flags[`BOCP_PSW_CY_BIT])
    else $error("true source did not set carry");

  AST_OR_NO_WRITE: assert property (@(posedge clock) disable iff (rst)
    (state_reg.state == BOCP_EXEC && state_reg.kind != BOCP_K_POP)
      |=> !dir_wr.we)
    else $error("or wrote a byte");

  AST_CARRY_KEPT: assert property (@(posedge clock) disable iff (rst)
    psw_prev[`BOCP_PSW_CY_BIT]
      |-> psw_flags[`BOCP_PSW_CY_BIT])
    else $error("carry cleared");

  for (genvar b = 0; b < 8; b++) begin : g_flag_hold
    if (b != `BOCP_PSW_CY_BIT) begin : g_other
      AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (rst)
        psw_flags[b] == psw_prev[b])
        else $error("flag bit changed");
    end
  end

  AST_DONE_PULSE: assert property (@(posedge clock) disable iff (rst)
    insn_done
      |=> !insn_done)
    else $error("done longer than one cycle");

  AST_READY_AFTER: assert property (@(posedge clock) disable iff (rst)
    insn_done
      |=> insn_ready)
    else $error("not ready after done");

  AST_LEN: assert property (@(posedge clock) disable iff (rst)
    insn_done
      |-> insn_length == `BOCP_INSN_BYTES)
    else $error("length wrong at done");

  AST_CYCLE_COUNT: assert property (@(posedge clock) disable iff (rst)
    insn_done
      |-> busy_age == `BOCP_INSN_CYCLES)
    else $error("done at wrong cycle");

  AST_AGE_BUSY: assert property (@(posedge clock) disable iff (rst)
    busy_age != 2'h0
      |-> !insn_ready)
    else $error("ready while busy");

  AST_READ_PULSE: assert property (@(posedge clock) disable iff (rst)
    ram_re
      |=> (!ram_re && dir_wr.we))
    else $error("read strobe not followed by write");

  AST_POP_READ_SP: assert property (@(posedge clock) disable iff (rst)
    ram_re
      |-> ram_raddr == stack_pointer)
    else $error("read address is not stack pointer");

  AST_NO_STRAY_READ: assert property (@(posedge clock) disable iff (rst)
    ram_re
      |-> !insn_ready)
    else $error("read strobe while idle");

  AST_NO_STRAY_WRITE: assert property (@(posedge clock) disable iff (rst)
    dir_wr.we
      |-> insn_done)
    else $error("write outside completion");

  AST_POP_NO_FLAGS: assert property (@(posedge clock) disable iff (rst)
    dir_wr.we
      |-> psw_flags == psw_prev)
    else $error("pop changed flags");

  AST_SP_HOLD: assert property (@(posedge clock) disable iff (rst)
    !dir_wr.we
      |-> stack_pointer == sp_prev)
    else $error("stack pointer moved without pop");

  AST_SP_WRAP: assert property (@(posedge clock) disable iff (rst)
    (dir_wr.we && dir_wr.addr != `BOCP_SP_ADDR && sp_prev == 8'h00)
      |-> stack_pointer == 8'hff)
    else $error("stack pointer did not wrap");

  AST_ILLEGAL_NO_EFFECT: assert property (@(posedge clock) disable iff (rst)
    insn_illegal
      |-> (!dir_wr.we && !ram_re && stack_pointer == sp_prev && psw_flags == psw_prev))
    else $error("refused opcode had an effect");

  COV_OR: cover property (@(posedge clock) disable iff (rst)
    state_reg.state == BOCP_EXEC && state_reg.kind == BOCP_K_OR);
  COV_ORN: cover property (@(posedge clock) disable iff (rst)
    state_reg.state == BOCP_EXEC && state_reg.kind == BOCP_K_ORN);
  COV_POP_SP: cover property (@(posedge clock) disable iff (rst)
    dir_wr.we && dir_wr.addr == `BOCP_SP_ADDR);
  COV_WRAP: cover property (@(posedge clock) disable iff (rst)
    dir_wr.we && sp_prev == 8'h00);
  COV_ILLEGAL: cover property (@(posedge clock) disable iff (rst)
    insn_illegal);
endmodule : bocp_core

// *** testbench/bocp_core_tb.sv ***
// self-checking bench for the bit-or-carry and stack-pop block
`timescale 1ns/1ns
`include "bocp_params.svh"
module bocp_core_tb;
  import bocp_pkg::*;
  logic       clock, rst, insn_valid, bit_value;
  bocp_insn_s insn;
  logic [7:0] ram_rdata, bit_addr, ram_raddr, stack_pointer, psw_flags;
  logic       insn_ready, insn_done, insn_illegal, ram_re;
  logic [1:0] insn_length;
  bocp_wr_s   dir_wr;
  integer     err_count = 0;
  integer     n_tests = 0;
  integer     seed = 32'hc9e78515;
  integer     i, k;
  logic [7:0] m_sp, m_psw, op;
  bocp_core uut (.clock(clock), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .bit_value(bit_value), .ram_rdata(ram_rdata), .insn_ready(insn_ready),
    .insn_done(insn_done), .insn_illegal(insn_illegal), .insn_length(insn_length),
    .bit_addr(bit_addr), .ram_raddr(ram_raddr), .ram_re(ram_re), .dir_wr(dir_wr),
    .stack_pointer(stack_pointer), .psw_flags(psw_flags));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    m_sp = `BOCP_SP_RESET;
    m_psw = `BOCP_PSW_RESET;
    #1;
    chk(stack_pointer, m_sp);
    chk(psw_flags, m_psw);
  endtask : do_reset
  task automatic run(input logic [7:0] op, input logic [7:0] opd, input logic bv,
                     input logic [7:0] rd);
    logic       legal;
    logic [7:0] sp0;
    integer     n;
    legal = op == `BOCP_OP_OR_BIT || op == `BOCP_OP_OR_NBIT || op == `BOCP_OP_POP;
    sp0 = m_sp;
    @(posedge clock);
    insn_valid <= 1'b1;
    insn <= {op, opd};
    bit_value <= bv;
    ram_rdata <= rd;
    @(posedge clock);
    insn_valid <= 1'b0;
    #1;
    chk({7'h00, insn_illegal}, {7'h00, !legal});
    chk({7'h00, insn_ready}, {7'h00, !legal});
    chk({7'h00, ram_re}, {7'h00, op == `BOCP_OP_POP});
    if (op == `BOCP_OP_POP) chk(ram_raddr, sp0);
    else if (legal) chk(bit_addr, opd);
    n = 1;
    while (legal && insn_done !== 1'b1 && n < 6) begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
    if (legal) begin
      chk(8'(n), {6'h00, `BOCP_INSN_CYCLES});
      chk({6'h00, insn_length}, {6'h00, `BOCP_INSN_BYTES});
      chk({7'h00, dir_wr.we}, {7'h00, op == `BOCP_OP_POP});
      if (op == `BOCP_OP_POP) begin
        chk(dir_wr.addr, opd);
        chk(dir_wr.data, rd);
        m_sp = (opd == `BOCP_SP_ADDR) ? rd : m_sp - 8'h01;
      end else if ((op == `BOCP_OP_OR_BIT) ? bv : ~bv) m_psw[7] = 1'b1;
    end
    chk(stack_pointer, m_sp);
    chk(psw_flags, m_psw);
    n = 0;
    while (insn_ready !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n = n + 1;
    end
  endtask : run
  initial begin
    #80000;
    err_count = err_count + 1;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    insn_valid = 1'b0;
    insn = '0;
    bit_value = 1'b0;
    ram_rdata = 8'h00;
    do_reset();
    run(`BOCP_OP_OR_BIT, 8'h10, 1'b0, 8'h5a);
    run(`BOCP_OP_OR_NBIT, 8'h11, 1'b1, 8'h5a);
    for (i = 0; i < 9; i++) run(`BOCP_OP_POP, 8'(8'h30 + i), 1'b0, 8'(8'h40 + i));
    run(`BOCP_OP_POP, `BOCP_SP_ADDR, 1'b0, 8'h20);
    run(8'hff, 8'h33, 1'b1, 8'h01);
    run(`BOCP_OP_OR_NBIT, 8'h12, 1'b0, 8'h00);
    do_reset();
    for (i = 0; i < 60; i++) begin
      k = $random(seed);
      case (k[1:0])
        2'h0: op = `BOCP_OP_OR_BIT;
        2'h1: op = `BOCP_OP_OR_NBIT;
        2'h2: op = `BOCP_OP_POP;
        default: op = 8'($random(seed));
      endcase
      run(op, (k[4:2] == 3'h0) ? `BOCP_SP_ADDR : 8'($random(seed)), k[5], 8'($random(seed)));
    end
    give_verdict();
  end
endmodule : bocp_core_tb
